// [verilog/bfc_consts.vh]
`ifndef BFC_CONSTS_VH
`define BFC_CONSTS_VH

// configuration offsets (byte offsets of the 16-bit registers)
`define BFC_OFF_COMMAND 8'h04
`define BFC_OFF_BRIDGE_CTL 8'h3E

// command register fields
`define BFC_CMD_IO_EN_BIT 0
`define BFC_CMD_MEM_EN_BIT 1
`define BFC_CMD_RESET 16'h0000

// bridge forwarding control fields
`define BFC_BC_ABORT_MODE_BIT 5
`define BFC_BC_FULL_DECODE_BIT 4
`define BFC_BC_VGA_EN_BIT 3
`define BFC_BC_ALIAS_BLOCK_BIT 2
`define BFC_BC_RESET 16'h0000

// legacy display decode ranges
`define BFC_VGA_MEM_LO 32'h000A_0000
`define BFC_VGA_MEM_HI 32'h000B_FFFF
`define BFC_VGA_IO_A_LO 10'h3B0
`define BFC_VGA_IO_A_HI 10'h3BB
`define BFC_VGA_IO_B_LO 10'h3C0
`define BFC_VGA_IO_B_HI 10'h3DF

// data returned for an aborted read
`define BFC_ALL_ONES 32'hFFFF_FFFF

// decision latency in clock cycles from request to answer
`define BFC_DECIDE_CYCLES 1

`endif

// [verilog/bfc_addr_decode.v]
`timescale 1ns/100ps
`default_nettype none
`include "bfc_consts.vh"

// purely combinational: decisions always follow the current register values
module bfc_addr_decode (
    input wire dirUp,
    input wire isIo,
    input wire [31:0] addr,
    input wire vgaEnable,
    input wire legacyDisplayFullDecode,
    input wire legacyIoAliasBlockEn,
    input wire ioSpaceEnable,
    input wire memSpaceEnable,
    input wire [31:0] ioBase,
    input wire [31:0] ioLimit,
    input wire [31:0] memBase,
    input wire [31:0] memLimit,
    input wire [31:0] prefBase,
    input wire [31:0] prefLimit,
    output reg forward
);
    wire low64k;
    wire [9:0] lowBits;
    wire vgaIoRange;
    wire vgaIoHit;
    wire vgaMemHit;
    wire inIoWindow;
    wire inMemWindow;
    wire aliasHit;

    assign low64k = (addr[31:16] == 16'h0000);
    assign lowBits = addr[9:0];
    assign vgaIoRange = ((lowBits >= `BFC_VGA_IO_A_LO)
        && (lowBits <= `BFC_VGA_IO_A_HI))
        || ((lowBits >= `BFC_VGA_IO_B_LO) && (lowBits <= `BFC_VGA_IO_B_HI));
    // bits 15:10 only take part in the match when full decode is on
    assign vgaIoHit = vgaEnable && low64k && vgaIoRange
        && (!legacyDisplayFullDecode
        || (addr[15:10] == 6'h00));
    assign vgaMemHit = vgaEnable && (addr >= `BFC_VGA_MEM_LO)
        && (addr <= `BFC_VGA_MEM_HI);
    assign inIoWindow = (addr >= ioBase) && (addr <= ioLimit);
    assign inMemWindow = ((addr >= memBase) && (addr <= memLimit))
        || ((addr >= prefBase) && (addr <= prefLimit));
    // top 768 bytes of every 1 KB block below 64 KB: offsets 100h..3FFh
    assign aliasHit = legacyIoAliasBlockEn && inIoWindow && low64k
        && (addr[9:8] != 2'b00);

    always @*
    begin
        forward = 1'b0;
        if (!dirUp)
        begin
            if (isIo)
            begin
                if (vgaIoHit)
                    forward = ioSpaceEnable;
                else
                    forward = ioSpaceEnable && inIoWindow
                        && !aliasHit;
            end
            else
            begin
                if (vgaMemHit)
                    forward = memSpaceEnable;
                else
                    forward = memSpaceEnable && inMemWindow;
            end
        end
        else
        begin
            if (isIo)
            begin
                if (vgaIoHit)
                    forward = 1'b0;
                else if (aliasHit)
                    forward = 1'b1;
                else
                    forward = !inIoWindow;
            end
            else
            begin
                if (vgaMemHit)
                    forward = 1'b0;
                else
                    forward = !inMemWindow;
            end
        end
    end
endmodule // bfc_addr_decode
`default_nettype wire

// [verilog/bfc_forward_ctl.v]
`timescale 1ns/100ps
`default_nettype none
`include "bfc_consts.vh"

module bfc_forward_ctl (
    input wire clock,
    input wire reset,
    // configuration access
    input wire cfgWrite,
    input wire cfgRead,
    input wire [7:0] cfgOffset,
    input wire [15:0] cfgWriteData,
    output reg cfgReadValid,
    output reg [15:0] cfgReadData,
    // windows held elsewhere in configuration space
    input wire [31:0] ioBase,
    input wire [31:0] ioLimit,
    input wire [31:0] memBase,
    input wire [31:0] memLimit,
    input wire [31:0] prefBase,
    input wire [31:0] prefLimit,
    // downstream request from the primary side
    input wire dnReqValid,
    input wire dnReqIsIo,
    input wire [31:0] dnReqAddr,
    output reg dnDecideValid,
    output reg dnForward,
    // upstream request from the secondary side
    input wire upReqValid,
    input wire upReqIsIo,
    input wire [31:0] upReqAddr,
    output reg upDecideValid,
    output reg upForward,
    // master abort seen on the secondary bus
    input wire masterAbort,
    input wire masterAbortRead,
    input wire masterAbortPosted,
    output reg pcieUnsupportedCpl,
    output reg pcieReadDataValid,
    output reg [31:0] pcieReadData,
    output reg pcieWriteDropped,
    output reg postedAbortError,
    // unsupported request completion seen from PCIe
    input wire pcieUnsupportedRcvd,
    input wire pcieUnsupportedRead,
    output reg pciTargetAbort,
    output reg pciReadDataValid,
    output reg [31:0] pciReadData,
    output reg pciWriteDropped,
    // mode levels for the datapath, registered one clock behind the control register
    output reg abortReportMode,
    output reg vgaEnableOut
);
    reg [15:0] commandReg_q;
    reg [15:0] bridgeCtl_q;
    reg [15:0] readMux_d;

    wire ioSpaceEnable;
    wire memSpaceEnable;
    wire abortMode;
    wire legacyDisplayFullDecode;
    wire vgaEnable;
    wire legacyIoAliasBlockEn;
    wire dnDecision;
    wire upDecision;

    assign ioSpaceEnable = commandReg_q[`BFC_CMD_IO_EN_BIT];
    assign memSpaceEnable = commandReg_q[`BFC_CMD_MEM_EN_BIT];
    assign abortMode = bridgeCtl_q[`BFC_BC_ABORT_MODE_BIT];
    assign legacyDisplayFullDecode = bridgeCtl_q[`BFC_BC_FULL_DECODE_BIT];
    assign vgaEnable = bridgeCtl_q[`BFC_BC_VGA_EN_BIT];
    assign legacyIoAliasBlockEn = bridgeCtl_q[`BFC_BC_ALIAS_BLOCK_BIT];

    // only the bits this block owns are stored; the rest read zero
    always @(posedge clock)
    begin
        if (reset)
        begin
            commandReg_q <= `BFC_CMD_RESET;
            bridgeCtl_q <= `BFC_BC_RESET;
        end
        else if (cfgWrite)
        begin
            if (cfgOffset == `BFC_OFF_COMMAND)
            begin
                commandReg_q[`BFC_CMD_IO_EN_BIT] <=
                    cfgWriteData[`BFC_CMD_IO_EN_BIT];
                commandReg_q[`BFC_CMD_MEM_EN_BIT] <=
                    cfgWriteData[`BFC_CMD_MEM_EN_BIT];
            end
            else if (cfgOffset == `BFC_OFF_BRIDGE_CTL)
            begin
                bridgeCtl_q[`BFC_BC_ABORT_MODE_BIT] <=
                    cfgWriteData[`BFC_BC_ABORT_MODE_BIT];
                bridgeCtl_q[`BFC_BC_FULL_DECODE_BIT] <=
                    cfgWriteData[`BFC_BC_FULL_DECODE_BIT];
                bridgeCtl_q[`BFC_BC_VGA_EN_BIT] <=
                    cfgWriteData[`BFC_BC_VGA_EN_BIT];
                bridgeCtl_q[`BFC_BC_ALIAS_BLOCK_BIT] <=
                    cfgWriteData[`BFC_BC_ALIAS_BLOCK_BIT];
            end
        end
    end

    always @*
    begin
        readMux_d = 16'h0000;
        if (cfgOffset == `BFC_OFF_COMMAND)
            readMux_d = commandReg_q;
        else if (cfgOffset == `BFC_OFF_BRIDGE_CTL)
            readMux_d = bridgeCtl_q;
    end

    always @(posedge clock)
    begin
        if (reset)
        begin
            cfgReadValid <= 1'b0;
            cfgReadData <= 16'h0000;
        end
        else
        begin
            cfgReadValid <= cfgRead;
            if (cfgRead)
                cfgReadData <= readMux_d;
        end
    end

    bfc_addr_decode uDnDecode (
        .dirUp(1'b0),
        .isIo(dnReqIsIo),
        .addr(dnReqAddr),
        .vgaEnable(vgaEnable),
        .legacyDisplayFullDecode(legacyDisplayFullDecode),
        .legacyIoAliasBlockEn(legacyIoAliasBlockEn),
        .ioSpaceEnable(ioSpaceEnable),
        .memSpaceEnable(memSpaceEnable),
        .ioBase(ioBase),
        .ioLimit(ioLimit),
        .memBase(memBase),
        .memLimit(memLimit),
        .prefBase(prefBase),
        .prefLimit(prefLimit),
        .forward(dnDecision)
    );

    bfc_addr_decode uUpDecode (
        .dirUp(1'b1),
        .isIo(upReqIsIo),
        .addr(upReqAddr),
        .vgaEnable(vgaEnable),
        .legacyDisplayFullDecode(legacyDisplayFullDecode),
        .legacyIoAliasBlockEn(legacyIoAliasBlockEn),
        .ioSpaceEnable(ioSpaceEnable),
        .memSpaceEnable(memSpaceEnable),
        .ioBase(ioBase),
        .ioLimit(ioLimit),
        .memBase(memBase),
        .memLimit(memLimit),
        .prefBase(prefBase),
        .prefLimit(prefLimit),
        .forward(upDecision)
    );

    // a request in the same cycle as a write sees the old register value
    always @(posedge clock)
    begin
        if (reset)
        begin
            dnDecideValid <= 1'b0;
            dnForward <= 1'b0;
            upDecideValid <= 1'b0;
            upForward <= 1'b0;
        end
        else
        begin
            dnDecideValid <= dnReqValid;
            dnForward <= dnReqValid && dnDecision;
            upDecideValid <= upReqValid;
            upForward <= upReqValid && upDecision;
        end
    end

    // downstream master abort handling
    always @(posedge clock)
    begin
        if (reset)
        begin
            pcieUnsupportedCpl <= 1'b0;
            pcieReadDataValid <= 1'b0;
            pcieReadData <= 32'h0000_0000;
            pcieWriteDropped <= 1'b0;
            postedAbortError <= 1'b0;
        end
        else
        begin
            pcieUnsupportedCpl <= 1'b0;
            pcieReadDataValid <= 1'b0;
            pcieWriteDropped <= 1'b0;
            postedAbortError <= 1'b0;
            if (masterAbort)
            begin
                if (abortMode)
                begin
                    // posted writes have no completion to carry the error
                    if (masterAbortPosted && !masterAbortRead)
                        postedAbortError <= 1'b1;
                    else
                        pcieUnsupportedCpl <= 1'b1;
                end
                else if (masterAbortRead)
                begin
                    pcieReadDataValid <= 1'b1;
                    pcieReadData <= `BFC_ALL_ONES;
                end
                else
                    pcieWriteDropped <= 1'b1;
            end
        end
    end

    // upstream unsupported request handling
    always @(posedge clock)
    begin
        if (reset)
        begin
            pciTargetAbort <= 1'b0;
            pciReadDataValid <= 1'b0;
            pciReadData <= 32'h0000_0000;
            pciWriteDropped <= 1'b0;
        end
        else
        begin
            pciTargetAbort <= 1'b0;
            pciReadDataValid <= 1'b0;
            pciWriteDropped <= 1'b0;
            if (pcieUnsupportedRcvd)
            begin
                if (abortMode)
                    pciTargetAbort <= 1'b1;
                else if (pcieUnsupportedRead)
                begin
                    pciReadDataValid <= 1'b1;
                    pciReadData <= `BFC_ALL_ONES;
                end
                else
                    pciWriteDropped <= 1'b1;
            end
        end
    end

    always @(posedge clock)
    begin
        if (reset)
        begin
            abortReportMode <= 1'b0;
            vgaEnableOut <= 1'b0;
        end
        else
        begin
            abortReportMode <= abortMode;
            vgaEnableOut <= vgaEnable;
        end
    end
endmodule // bfc_forward_ctl
`default_nettype wire

// [test/bfc_forward_ctl_props.sv]
`timescale 1ns/100ps
`default_nettype none
module bfc_forward_ctl_props (
    input wire logic clock,
    input wire logic reset,
    input wire logic cfgRead,
    input wire logic cfgReadValid,
    input wire logic dnReqValid,
    input wire logic dnDecideValid,
    input wire logic dnForward,
    input wire logic upReqValid,
    input wire logic upDecideValid,
    input wire logic masterAbort,
    input wire logic masterAbortRead,
    input wire logic masterAbortPosted,
    input wire logic pcieUnsupportedCpl,
    input wire logic pcieReadDataValid,
    input wire logic [31:0] pcieReadData,
    input wire logic postedAbortError,
    input wire logic pcieUnsupportedRcvd,
    input wire logic pciTargetAbort,
    input wire logic abortReportMode
);
default clocking cb @(posedge clock);
endclocking
default disable iff (reset);
property p_dn_lat;
    dnReqValid |=> dnDecideValid;
endproperty
a_dn_lat: assert property (p_dn_lat)
    else $error("down decision missing");
property p_dn_idle;
    !dnReqValid |=> !dnDecideValid && !dnForward;
endproperty
a_dn_idle: assert property (p_dn_idle)
    else $error("down decision without request");
property p_up_lat;
    upReqValid |=> upDecideValid;
endproperty
a_up_lat: assert property (p_up_lat)
    else $error("up decision missing");
property p_ur;
    masterAbort && !masterAbortPosted |=> pcieUnsupportedCpl == abortReportMode;
endproperty
a_ur: assert property (p_ur)
    else $error("unsupported completion wrong");
property p_quiet;
    masterAbort && masterAbortRead |=> pcieReadDataValid != abortReportMode;
endproperty
a_quiet: assert property (p_quiet)
    else $error("silent read wrong");
property p_ones;
    pcieReadDataValid |-> pcieReadData == 32'hFFFF_FFFF;
endproperty
a_ones: assert property (p_ones)
    else $error("read data not all ones");
property p_post;
    masterAbort && masterAbortPosted |=> postedAbortError == abortReportMode;
endproperty
a_post: assert property (p_post)
    else $error("posted abort error wrong");
property p_ta;
    pcieUnsupportedRcvd |=> pciTargetAbort == abortReportMode;
endproperty
a_ta: assert property (p_ta)
    else $error("target abort wrong");
property p_cfg;
    cfgRead |=> cfgReadValid;
endproperty
a_cfg: assert property (p_cfg)
    else $error("read data valid missing");
c_fwd: cover property (dnReqValid ##1 dnForward);
c_ur: cover property (masterAbort ##1 pcieUnsupportedCpl);
c_ta: cover property (pcieUnsupportedRcvd ##1 pciTargetAbort);
endmodule // bfc_forward_ctl_props
`default_nettype wire

// [test/bfc_pci_master.sv]
`timescale 1ns/100ps
`default_nettype none
module bfc_pci_master (
    input wire logic clock,
    output logic upReqValid = 1'b0,
    output logic upReqIsIo = 1'b0,
    output logic [31:0] upReqAddr = 32'h0000_0000,
    output logic masterAbort = 1'b0,
    output logic masterAbortRead = 1'b0,
    output logic masterAbortPosted = 1'b0
);
task req(input logic io, input logic [31:0] a);
    @(posedge clock);
    upReqValid <= 1'b1;
    upReqIsIo <= io;
    upReqAddr <= a;
    @(posedge clock);
    upReqValid <= 1'b0;
    // released bus must not keep the last address
    upReqAddr <= ~a;
endtask
task abort(input logic rd, input logic po);
    @(posedge clock);
    masterAbort <= 1'b1;
    masterAbortRead <= rd;
    masterAbortPosted <= po;
    @(posedge clock);
    masterAbort <= 1'b0;
    masterAbortRead <= ~rd;
endtask
endmodule // bfc_pci_master
`default_nettype wire

// [test/bridge_legacy_decode_abort_ctl_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "bfc_consts.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failCount++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module bridge_legacy_decode_abort_ctl_bench;
logic clock = 0, reset = 1, cfgWrite = 0, cfgRead = 0;
logic [7:0] cfgOffset = 8'h00;
logic [15:0] cfgWriteData = 16'h0000, cfgReadData;
logic [31:0] ioBase = 0, ioLimit = 0, memBase = 0, memLimit = 0;
logic [31:0] prefBase = 32'hFFFF_FFFF, prefLimit = 0, dnReqAddr = 0;
logic dnReqValid = 0, dnReqIsIo = 0, pcieUnsupportedRcvd = 0;
logic pcieUnsupportedRead = 0, cfgReadValid, dnDecideValid, dnForward;
logic upReqValid, upReqIsIo, upDecideValid, upForward, masterAbort;
logic masterAbortRead, masterAbortPosted, pcieUnsupportedCpl;
logic pcieReadDataValid, pcieWriteDropped, postedAbortError;
logic pciTargetAbort, pciReadDataValid, pciWriteDropped;
logic abortReportMode, vgaEnableOut;
logic [31:0] upReqAddr, pcieReadData, pciReadData;
int failCount = 0, checks = 0;
always #12.5 clock = ~clock;
bfc_pci_master i_master (.clock, .upReqValid, .upReqIsIo, .upReqAddr,
    .masterAbort, .masterAbortRead, .masterAbortPosted);
bfc_forward_ctl i_dut (.clock, .reset, .cfgWrite, .cfgRead, .cfgOffset,
    .cfgWriteData, .cfgReadValid, .cfgReadData, .ioBase, .ioLimit,
    .memBase, .memLimit, .prefBase, .prefLimit, .dnReqValid, .dnReqIsIo,
    .dnReqAddr, .dnDecideValid, .dnForward, .upReqValid, .upReqIsIo,
    .upReqAddr, .upDecideValid, .upForward, .masterAbort, .masterAbortRead,
    .masterAbortPosted, .pcieUnsupportedCpl, .pcieReadDataValid,
    .pcieReadData, .pcieWriteDropped, .postedAbortError,
    .pcieUnsupportedRcvd, .pcieUnsupportedRead, .pciTargetAbort,
    .pciReadDataValid, .pciReadData, .pciWriteDropped, .abortReportMode,
    .vgaEnableOut);
task give_verdict;
    $display("checks=%0d failCount=%0d", checks, failCount);
    if (failCount == 0 && checks > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
endtask
task wr(input logic [7:0] o, input logic [15:0] d);
    @(posedge clock);
    cfgWrite <= 1;
    cfgOffset <= o;
    cfgWriteData <= d;
    @(posedge clock);
    cfgWrite <= 0;
endtask
task rd(input logic [7:0] o, input logic [15:0] e);
    @(posedge clock);
    cfgRead <= 1;
    cfgOffset <= o;
    @(posedge clock);
    cfgRead <= 0;
    #1 `CHK({cfgReadValid, cfgReadData}, {1'b1, e})
endtask
task dn(input logic io, input logic [31:0] a, input logic e);
    @(posedge clock);
    dnReqValid <= 1;
    dnReqIsIo <= io;
    dnReqAddr <= a;
    @(posedge clock);
    dnReqValid <= 0;
    #1 `CHK({dnDecideValid, dnForward}, {1'b1, e})
endtask
task up(input logic io, input logic [31:0] a, input logic e);
    i_master.req(io, a);
    #1 `CHK({upDecideValid, upForward}, {1'b1, e})
endtask
task ab(input logic r, input logic p, input logic [3:0] e);
    i_master.abort(r, p);
    #1 `CHK({pcieUnsupportedCpl, pcieReadDataValid, pcieWriteDropped,
        postedAbortError}, e)
endtask
task ur(input logic r, input logic [2:0] e);
    @(posedge clock);
    pcieUnsupportedRcvd <= 1;
    pcieUnsupportedRead <= r;
    @(posedge clock);
    pcieUnsupportedRcvd <= 0;
    #1 `CHK({pciTargetAbort, pciReadDataValid, pciWriteDropped}, e)
endtask
task t_regs;
    rd(`BFC_OFF_COMMAND, 16'h0000);
    rd(`BFC_OFF_BRIDGE_CTL, 16'h0000);
    wr(`BFC_OFF_BRIDGE_CTL, 16'hFFFF);
    rd(`BFC_OFF_BRIDGE_CTL, 16'h003C);
    rd(8'h10, 16'h0000);
    $display("test regs done");
endtask
task t_vga;
    wr(`BFC_OFF_COMMAND, 16'h0003);
    wr(`BFC_OFF_BRIDGE_CTL, 16'h0008);
    dn(0, 32'h000A_0000, 1);
    `CHK(vgaEnableOut, 1'b1)
    dn(0, 32'h000B_FFFF, 1);
    dn(0, 32'h000C_0000, 0);
    dn(1, 32'h0000_03BB, 1);
    dn(1, 32'h0000_03BC, 0);
    dn(1, 32'h0000_03DF, 1);
    dn(1, 32'h0001_03C0, 0);
    dn(1, 32'h0000_FFC0, 1);
    wr(`BFC_OFF_BRIDGE_CTL, 16'h0018);
    dn(1, 32'h0000_FFC0, 0);
    up(0, 32'h000A_0000, 0);
    up(1, 32'h0000_03C0, 0);
    wr(`BFC_OFF_BRIDGE_CTL, 16'h000C);
    dn(1, 32'h0000_03C0, 1);
    wr(`BFC_OFF_COMMAND, 16'h0002);
    dn(1, 32'h0000_03C0, 0);
    wr(`BFC_OFF_COMMAND, 16'h0001);
    dn(0, 32'h000A_0000, 0);
    $display("test vga done");
endtask
task t_alias;
    ioLimit <= 32'h0001_FFFF;
    wr(`BFC_OFF_BRIDGE_CTL, 16'h0004);
    dn(1, 32'h0000_0100, 0);
    dn(1, 32'h0000_0400, 1);
    dn(1, 32'h0001_0100, 1);
    up(1, 32'h0000_0100, 1);
    wr(`BFC_OFF_BRIDGE_CTL, 16'h0000);
    dn(1, 32'h0000_0100, 1);
    dn(1, 32'h0000_03C0, 1);
    wr(`BFC_OFF_BRIDGE_CTL, 16'h0010);
    dn(1, 32'h0000_FFC0, 1);
    ioLimit <= 32'h0000_0000;
    dn(1, 32'h0000_03C0, 0);
    $display("test alias done");
endtask
task t_abort;
    wr(`BFC_OFF_BRIDGE_CTL, 16'h0000);
    ab(1, 0, 4'b0100);
    `CHK(pcieReadData, `BFC_ALL_ONES)
    ab(0, 0, 4'b0010);
    ur(1, 3'b010);
    `CHK(pciReadData, `BFC_ALL_ONES)
    ur(0, 3'b001);
    wr(`BFC_OFF_BRIDGE_CTL, 16'h0020);
    ab(1, 0, 4'b1000);
    ab(0, 1, 4'b0001);
    ur(1, 3'b100);
    $display("test abort done");
endtask
initial
begin
    repeat (4) @(posedge clock);
    reset <= 0;
    t_regs;
    t_vga;
    t_alias;
    t_abort;
    give_verdict;
end
initial
begin
    #50000;
    failCount++;
    give_verdict;
end
endmodule // bridge_legacy_decode_abort_ctl_bench
bind bfc_forward_ctl bfc_forward_ctl_props i_props (.clock, .reset,
    .cfgRead, .cfgReadValid, .dnReqValid, .dnDecideValid, .dnForward,
    .upReqValid, .upDecideValid, .masterAbort, .masterAbortRead,
    .masterAbortPosted, .pcieUnsupportedCpl, .pcieReadDataValid,
    .pcieReadData, .postedAbortError, .pcieUnsupportedRcvd,
    .pciTargetAbort, .abortReportMode);
`default_nettype wire
